// ---- design/acs_agc_sense.sv ----
// Overview of operation
// - digital gain limit code removes the top zero to three digital gain steps
// - front amp ceiling code forces that many combined front stage reduction steps
// - target code picks 24,27,30,33,36,38,40,42 dB; reset code 33 dB
// - order bit 1 reduces first stage first, 0 bottoms second stage first
// - relative code 00 disables; others need 6, 10 or 14 dB rise
// - absolute threshold is signed 1 dB steps relative to amplitude target
// - absolute code 1000 disables absolute carrier sense
// - signal strength equals filter amplitude when gain is not reduced
// - absolute codes -7..7 mean that many dB around the target
module acs_agc_sense import acs_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ACS_AW-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [7:0] amp_db_i,
   input wire logic amp_valid_i,
   output logic [2:0] first_stage_red_o,
   output logic [2:0] second_stage_red_o,
   output logic [2:0] digital_gain_o,
   output logic [9:0] rssi_o,
   output logic carrier_sense_o,
   output logic irq_o
);
   typedef struct packed {
      logic [7:0] gl;
      logic [7:0] pt;
      logic [ACS_IRQ_W-1:0] stat;
      logic [ACS_IRQ_W-1:0] mask;
      logic [7:0] rdata;
      acs_mode_e mode;
      logic [3:0] settle;
      logic [2:0] first;
      logic [2:0] second;
      logic [2:0] dig;
      logic [9:0] rssi;
      logic [9:0] baseline;
      logic cs;
   } acs_state_s;

   acs_state_s st_r;
   acs_state_s st_nxt;

   logic [1:0] digital_gain_ceiling;
   logic [2:0] front_amp_gain_ceiling;
   logic [2:0] amplitude_target;
   logic stage_reduction_order;
   logic [1:0] relative_sense_threshold;
   logic [3:0] absolute_sense_threshold;
   logic [2:0] dig_max;
   logic [3:0] front_min;
   logic [3:0] front_sum;
   logic [2:0] dig_red;
   logic [9:0] red_db;
   logic [9:0] rssi_new;
   logic [7:0] target_db;
   logic amp_high;
   logic amp_low;
   logic decide;
   logic abs_hit;
   logic rel_hit;
   logic [2:0] first_step;
   logic [2:0] second_step;
   logic [2:0] dig_step;
   logic gain_moved;
   logic wr_gl;
   logic wr_pt;
   logic wr_stat;
   logic wr_mask;
   logic [ACS_IRQ_W-1:0] events;

   assign digital_gain_ceiling = st_r.gl[ACS_DIG_CEIL_LSB +: 2];
   assign front_amp_gain_ceiling = st_r.gl[ACS_FRONT_CEIL_LSB +: 3];
   assign amplitude_target = st_r.gl[ACS_TARGET_LSB +: 3];
   assign stage_reduction_order = st_r.pt[ACS_ORDER_BIT];
   assign relative_sense_threshold = st_r.pt[ACS_REL_LSB +: 2];
   assign absolute_sense_threshold = st_r.pt[ACS_ABS_LSB +: 4];

   assign dig_max = ACS_DIG_TOP - {1'b0, digital_gain_ceiling};
   assign front_min = {1'b0, front_amp_gain_ceiling};
   assign target_db = acs_target_db(amplitude_target);
   assign front_sum = {1'b0, st_r.first} + {1'b0, st_r.second};

   // loop decision against the target with a small dead band
   assign amp_high = {1'b0, amp_db_i} > ({1'b0, target_db} + {1'b0, ACS_DEADBAND_DB});
   assign amp_low = ({1'b0, amp_db_i} + {1'b0, ACS_DEADBAND_DB}) < {1'b0, target_db};
   assign decide = amp_valid_i && (st_r.mode == ACS_TRACK);

   acs_gain_stepper u_stepper (
      .first_i(st_r.first),
      .second_i(st_r.second),
      .dig_i(st_r.dig),
      .dig_max_i(dig_max),
      .front_min_i(front_min),
      .first_first_i(stage_reduction_order),
      .down_i(decide && amp_high),
      .up_i(decide && amp_low),
      .first_o(first_step),
      .second_o(second_step),
      .dig_o(dig_step)
   );

   assign gain_moved = (first_step != st_r.first) || (second_step != st_r.second) ||
                       (dig_step != st_r.dig);

   // strength seen at the antenna: amplitude plus the gain taken away
   assign dig_red = (st_r.dig >= dig_max) ? 3'h0 : (dig_max - st_r.dig);
   assign red_db = 10'(front_sum) * 10'(ACS_FRONT_STEP_DB) +
                   10'(dig_red) * 10'(ACS_DIG_STEP_DB);
   assign rssi_new = {2'b00, amp_db_i} + red_db;

   acs_sense_cmp u_sense (
      .rssi_i(st_r.rssi),
      .baseline_i(st_r.baseline),
      .target_code_i(amplitude_target),
      .abs_thr_i(absolute_sense_threshold),
      .rel_code_i(relative_sense_threshold),
      .abs_hit_o(abs_hit),
      .rel_hit_o(rel_hit)
   );

   assign wr_gl = wr_i && (addr_i == ACS_GAIN_LIMITS_OFS);
   assign wr_pt = wr_i && (addr_i == ACS_PRIO_THR_OFS);
   assign wr_stat = wr_i && (addr_i == ACS_IRQ_STAT_OFS);
   assign wr_mask = wr_i && (addr_i == ACS_IRQ_MASK_OFS);

   always_comb begin
      st_nxt = st_r;
      events = '0;
      // registers
      if (wr_gl) begin
         st_nxt.gl = wdata_i;
      end
      if (wr_pt) begin
         st_nxt.pt = wdata_i & ACS_PRIO_THR_WMASK;
      end
      if (wr_mask) begin
         st_nxt.mask = wdata_i[ACS_IRQ_W-1:0];
      end
      st_nxt.rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            ACS_GAIN_LIMITS_OFS: st_nxt.rdata = st_r.gl;
            ACS_PRIO_THR_OFS: st_nxt.rdata = st_r.pt;
            ACS_IRQ_STAT_OFS: st_nxt.rdata = {6'h00, st_r.stat};
            ACS_IRQ_MASK_OFS: st_nxt.rdata = {6'h00, st_r.mask};
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      // gain stages, ceilings enforced in every cycle
      st_nxt.first = first_step;
      st_nxt.second = second_step;
      st_nxt.dig = dig_step;
      case (st_r.mode)
         ACS_TRACK: begin
            if (decide && gain_moved) begin
               st_nxt.mode = ACS_SETTLE;
               st_nxt.settle = ACS_SETTLE_SAMPLES;
            end
         end
         ACS_SETTLE: begin
            if (amp_valid_i) begin
               st_nxt.settle = st_r.settle - 4'h1;
               if (st_r.settle == 4'h1) begin
                  st_nxt.mode = ACS_TRACK;
               end
            end
         end
         default: begin
            st_nxt.mode = ACS_TRACK;
         end
      endcase
      // strength and quiet baseline
      if (amp_valid_i) begin
         st_nxt.rssi = rssi_new;
         if (!st_r.cs && rssi_new < st_r.baseline) begin
            st_nxt.baseline = rssi_new;
         end
      end
      st_nxt.cs = abs_hit || rel_hit;
      if (st_r.cs && !st_nxt.cs) begin
         st_nxt.baseline = st_r.rssi;
      end
      events[ACS_IRQ_CS_ON] = st_nxt.cs && !st_r.cs;
      events[ACS_IRQ_CS_OFF] = !st_nxt.cs && st_r.cs;
      // set wins over a write-one clear
      if (wr_stat) begin
         st_nxt.stat = (st_r.stat & ~wdata_i[ACS_IRQ_W-1:0]) | events;
      end else begin
         st_nxt.stat = st_r.stat | events;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
         st_r.gl <= ACS_GAIN_LIMITS_RST;
         st_r.pt <= ACS_PRIO_THR_RST;
         st_r.stat <= ACS_IRQ_RST;
         st_r.mask <= ACS_IRQ_RST;
         st_r.mode <= ACS_TRACK;
         st_r.dig <= ACS_DIG_TOP;
         st_r.baseline <= ACS_BASELINE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o = st_r.rdata;
   assign first_stage_red_o = st_r.first;
   assign second_stage_red_o = st_r.second;
   assign digital_gain_o = st_r.dig;
   assign rssi_o = st_r.rssi;
   assign carrier_sense_o = st_r.cs;
   assign irq_o = |(st_r.stat & st_r.mask);

   default clocking acs_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   dig_ceiling_a: assert property (
      (st_r.dig > dig_max) && !wr_gl |=> (st_r.dig == $past(dig_max)))
      else $error("digital gain above its ceiling was not clamped");

   front_ceiling_a: assert property (
      (front_sum < front_min) && !wr_gl && (st_r.dig <= dig_max)
      |=> (front_sum == $past(front_sum) + 4'h1))
      else $error("front stage reduction did not rise toward the ceiling");

   target_pick_a: assert property (
      (absolute_sense_threshold == 4'h0)
      |-> (abs_hit == (int'(st_r.rssi) >= int'(target_db))))
      else $error("absolute hit not aligned with selected target");

   target_reset_a: assert property (
      $rose(rst_b_i) |-> (target_db == 8'h21))
      else $error("target after reset is not 33 dB");

   first_stage_order_a: assert property (
      decide && amp_high && stage_reduction_order && (st_r.dig <= dig_max) &&
      (st_r.first != ACS_STAGE_MAX_RED) && !wr_gl && !wr_pt
      |=> (st_r.first == $past(st_r.first) + 3'h1) && $stable(st_r.second))
      else $error("first stage not reduced first");

   second_stage_order_a: assert property (
      decide && amp_high && !stage_reduction_order && (st_r.dig <= dig_max) &&
      (st_r.second != ACS_STAGE_MAX_RED) && !wr_gl && !wr_pt
      |=> (st_r.second == $past(st_r.second) + 3'h1) && $stable(st_r.first))
      else $error("second stage not driven down first");

   rel_disable_a: assert property (
      (relative_sense_threshold == ACS_REL_OFF) |-> !rel_hit)
      else $error("relative sense fired while disabled");

   rel_level_a: assert property (
      (relative_sense_threshold != ACS_REL_OFF)
      |-> (rel_hit == (int'(st_r.rssi) >= int'(st_r.baseline) +
                       int'(acs_rel_db(relative_sense_threshold)))))
      else $error("relative sense level wrong");

   abs_signed_a: assert property (
      (absolute_sense_threshold != ACS_ABS_OFF)
      |-> (abs_hit == (int'(st_r.rssi) >= int'(target_db) +
                       int'($signed(absolute_sense_threshold)))))
      else $error("absolute threshold not signed around target");

   abs_disable_a: assert property (
      (absolute_sense_threshold == ACS_ABS_OFF) |-> !abs_hit)
      else $error("absolute sense fired while disabled");

   rssi_plain_a: assert property (
      amp_valid_i && (front_sum == 4'h0) && (st_r.dig >= dig_max)
      |=> (st_r.rssi == {2'b00, $past(amp_db_i)}))
      else $error("strength differs from amplitude at full gain");

   abs_low_end_a: assert property (
      (absolute_sense_threshold == 4'h9) && (int'(st_r.rssi) == int'(target_db) - 8)
      |-> !abs_hit)
      else $error("minus seven code hit one dB too low");

   sense_follow_a: assert property (
      (abs_hit || rel_hit) ##1 !(abs_hit || rel_hit) |-> carrier_sense_o ##1 !carrier_sense_o)
      else $error("carrier sense does not follow conditions");

   sense_irq_a: assert property (
      $rose(carrier_sense_o) |-> st_r.stat[ACS_IRQ_CS_ON])
      else $error("carrier sense rise not flagged");

   dig_in_range_a: assert property (
      !$past(wr_gl) |-> (st_r.dig <= dig_max))
      else $error("digital gain above its ceiling");

   front_in_range_a: assert property (
      (front_sum >= front_min) |=> (front_sum >= $past(front_min)))
      else $error("front stage reduction fell below the ceiling");

   sense_fall_irq_a: assert property (
      $fell(carrier_sense_o) |-> st_r.stat[ACS_IRQ_CS_OFF])
      else $error("carrier sense fall not flagged");
endmodule

// ---- design/acs_gain_stepper.sv ----
module acs_gain_stepper import acs_pkg::*; (
   input wire logic [2:0] first_i,
   input wire logic [2:0] second_i,
   input wire logic [2:0] dig_i,
   input wire logic [2:0] dig_max_i,
   input wire logic [3:0] front_min_i,
   input wire logic first_first_i,
   input wire logic down_i,
   input wire logic up_i,
   output logic [2:0] first_o,
   output logic [2:0] second_o,
   output logic [2:0] dig_o
);
   logic [3:0] front_sum;
   logic front_under;
   logic red_first;
   logic red_second;
   logic raise_second;

   assign front_sum = {1'b0, first_i} + {1'b0, second_i};
   assign front_under = front_sum < front_min_i;
   // stage order for reduction
   assign red_first = first_first_i ? (first_i != ACS_STAGE_MAX_RED) :
                      (second_i == ACS_STAGE_MAX_RED && first_i != ACS_STAGE_MAX_RED);
   assign red_second = first_first_i ?
                       (first_i == ACS_STAGE_MAX_RED && second_i != ACS_STAGE_MAX_RED) :
                       (second_i != ACS_STAGE_MAX_RED);
   // gain comes back in the reverse order
   assign raise_second = first_first_i ? (second_i != 3'h0) : (first_i == 3'h0);

   always_comb begin
      first_o = first_i;
      second_o = second_i;
      dig_o = dig_i;
      if (dig_i > dig_max_i) begin
         dig_o = dig_max_i;
      end else if (front_under || down_i) begin
         if (red_first) begin
            first_o = first_i + 3'h1;
         end else if (red_second) begin
            second_o = second_i + 3'h1;
         end else if (!front_under && dig_i != 3'h0) begin
            dig_o = dig_i - 3'h1;
         end
      end else if (up_i) begin
         if (dig_i < dig_max_i) begin
            dig_o = dig_i + 3'h1;
         end else if (front_sum > front_min_i) begin
            if (raise_second) begin
               second_o = second_i - 3'h1;
            end else begin
               first_o = first_i - 3'h1;
            end
         end
      end
   end
endmodule

// ---- design/acs_pkg.sv ----
package acs_pkg;
   // register map
   localparam int ACS_AW = 16;
   localparam logic [15:0] ACS_GAIN_LIMITS_OFS = 16'hdf17;
   localparam logic [15:0] ACS_PRIO_THR_OFS = 16'hdf18;
   localparam logic [15:0] ACS_IRQ_STAT_OFS = 16'hdf30;
   localparam logic [15:0] ACS_IRQ_MASK_OFS = 16'hdf31;
   localparam logic [7:0] ACS_GAIN_LIMITS_RST = 8'h03;
   localparam logic [7:0] ACS_PRIO_THR_RST = 8'h40;
   localparam logic [7:0] ACS_PRIO_THR_WMASK = 8'h7f;
   localparam logic [1:0] ACS_IRQ_RST = 2'h0;
   // field positions
   localparam int ACS_DIG_CEIL_LSB = 6;
   localparam int ACS_FRONT_CEIL_LSB = 3;
   localparam int ACS_TARGET_LSB = 0;
   localparam int ACS_ORDER_BIT = 6;
   localparam int ACS_REL_LSB = 4;
   localparam int ACS_ABS_LSB = 0;
   localparam int ACS_IRQ_CS_ON = 0;
   localparam int ACS_IRQ_CS_OFF = 1;
   localparam int ACS_IRQ_W = 2;
   // codes and gain steps
   localparam logic [3:0] ACS_ABS_OFF = 4'h8;
   localparam logic [1:0] ACS_REL_OFF = 2'h0;
   localparam logic [2:0] ACS_DIG_TOP = 3'h7;
   localparam logic [2:0] ACS_STAGE_MAX_RED = 3'h7;
   localparam logic [7:0] ACS_FRONT_STEP_DB = 8'h03;
   localparam logic [7:0] ACS_DIG_STEP_DB = 8'h03;
   localparam logic [7:0] ACS_DEADBAND_DB = 8'h02;
   localparam logic [3:0] ACS_SETTLE_SAMPLES = 4'h4;
   localparam logic [9:0] ACS_BASELINE_RST = 10'h3ff;

   typedef enum logic [1:0] {
      ACS_TRACK = 2'b00,
      ACS_SETTLE = 2'b01
   } acs_mode_e;

   function automatic logic [7:0] acs_target_db(input logic [2:0] code);
      logic [7:0] db;
      case (code)
         3'h0: db = 8'h18;
         3'h1: db = 8'h1b;
         3'h2: db = 8'h1e;
         3'h3: db = 8'h21;
         3'h4: db = 8'h24;
         3'h5: db = 8'h26;
         3'h6: db = 8'h28;
         default: db = 8'h2a;
      endcase
      return db;
   endfunction

   function automatic logic [7:0] acs_rel_db(input logic [1:0] code);
      logic [7:0] db;
      case (code)
         2'h1: db = 8'h06;
         2'h2: db = 8'h0a;
         2'h3: db = 8'h0e;
         default: db = 8'h00;
      endcase
      return db;
   endfunction
endpackage

// ---- design/acs_sense_cmp.sv ----
module acs_sense_cmp import acs_pkg::*; (
   input wire logic [9:0] rssi_i,
   input wire logic [9:0] baseline_i,
   input wire logic [2:0] target_code_i,
   input wire logic [3:0] abs_thr_i,
   input wire logic [1:0] rel_code_i,
   output logic abs_hit_o,
   output logic rel_hit_o
);
   logic [9:0] abs_level;
   logic [10:0] rel_level;

   // signed offset in 1 dB steps around the selected target
   assign abs_level = {2'b00, acs_target_db(target_code_i)} +
                      {{6{abs_thr_i[3]}}, abs_thr_i};
   assign abs_hit_o = (abs_thr_i != ACS_ABS_OFF) && (rssi_i >= abs_level);
   // rise above the quiet baseline
   assign rel_level = {1'b0, baseline_i} + {3'b000, acs_rel_db(rel_code_i)};
   assign rel_hit_o = (rel_code_i != ACS_REL_OFF) && ({1'b0, rssi_i} >= rel_level);
endmodule

// ---- testbench/acs_agc_sense_test.sv ----
module acs_agc_sense_test import acs_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] level = 8'h14;
   logic [7:0] rdata_o, amp_db;
   logic amp_valid, carrier_sense_o, irq_o;
   logic [2:0] first_stage_red_o, second_stage_red_o, digital_gain_o;
   logic [9:0] rssi_o;
   int fail_count = 0;
   int n_tests = 0;
   int seed = 32'hedb5_f3cf;
   int c, thr;

   always #5 clk_i = ~clk_i;

   acs_agc_sense i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .amp_db_i(amp_db), .amp_valid_i(amp_valid),
      .first_stage_red_o(first_stage_red_o), .second_stage_red_o(second_stage_red_o),
      .digital_gain_o(digital_gain_o), .rssi_o(rssi_o), .carrier_sense_o(carrier_sense_o),
      .irq_o(irq_o));
   acs_chain_model i_chain (.clk_i(clk_i), .rst_b_i(rst_b_i), .level_i(level),
      .first_i(first_stage_red_o), .second_i(second_stage_red_o), .dig_i(digital_gain_o),
      .amp_db_o(amp_db), .amp_valid_o(amp_valid));

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(nm, {2'b00, rdata_o}, {2'b00, e});
   endtask

   task automatic hold(input logic [7:0] lv, input int n);
      @(posedge clk_i);
      level <= lv;
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // amplitude target in dB for a target code
   function automatic int tdb(input int code);
      return (code < 5) ? 24 + 3 * code : 28 + 2 * code;
   endfunction

   // relative rise in dB for a relative code
   function automatic int rdb(input int code);
      return (code == 0) ? 0 : 4 * code + 2;
   endfunction

   // expected first stage reduction for 24 dB of excess at full ceiling
   function automatic logic [9:0] exp_first(input int ord);
      return (ord == 1) ? 10'h007 : 10'h001;
   endfunction

   initial begin
      #400_000;
      fail_count++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1 check("dig_rst", {7'h00, digital_gain_o}, 10'h007);
      rd(ACS_GAIN_LIMITS_OFS, 8'h03, "gain_rst");
      @(posedge clk_i);
      #1 check("rd_idle", {2'b00, rdata_o}, 10'h000);
      rd(ACS_PRIO_THR_OFS, 8'h40, "prio_rst");
      rd(ACS_IRQ_STAT_OFS, 8'h00, "stat_rst");
      rd(ACS_IRQ_MASK_OFS, 8'h00, "mask_rst");
      rd(16'hdf20, 8'h00, "unmapped");
      wr(ACS_PRIO_THR_OFS, 8'hff);
      rd(ACS_PRIO_THR_OFS, 8'h7f, "prio_rw");
      wr(ACS_GAIN_LIMITS_OFS, 8'h03);
      for (int o = 1; o >= 0; o--) begin
         wr(ACS_PRIO_THR_OFS, 8'h08 | 8'(o << 6));
         hold(8'h21, 400);
         check("first_idle", {7'h00, first_stage_red_o}, 10'h000);
         check("rssi_amp", rssi_o, 10'h021);
         hold(8'h39, 400);
         check("first_red", {7'h00, first_stage_red_o}, exp_first(o));
         check("second_red", {7'h00, second_stage_red_o}, exp_first(1 - o));
         check("rssi_red", rssi_o, 10'h039);
      end
      for (int i = 0; i < 8; i++) begin
         c = (i == 0) ? -7 : (i == 1) ? 7 : int'({$random(seed)} % 15) - 7;
         thr = tdb(i) + c;
         wr(ACS_GAIN_LIMITS_OFS, {5'h00, 3'(i)});
         wr(ACS_PRIO_THR_OFS, {4'h4, 4'(c)});
         hold(8'(thr - 1), 300);
         check("abs_below", {9'h000, carrier_sense_o}, 10'h000);
         hold(8'(thr), 300);
         check("abs_at", {9'h000, carrier_sense_o}, 10'h001);
      end
      wr(ACS_PRIO_THR_OFS, 8'h48);
      hold(8'h40, 300);
      check("abs_off", {9'h000, carrier_sense_o}, 10'h000);
      wr(ACS_GAIN_LIMITS_OFS, 8'h00);
      for (int r = 1; r < 4; r++) begin
         wr(ACS_PRIO_THR_OFS, 8'h40);
         hold(8'h1e, 300);
         hold(8'h14, 300);
         check("cs_fall", {9'h000, carrier_sense_o}, 10'h000);
         wr(ACS_PRIO_THR_OFS, {2'b01, 2'(r), 4'h8});
         hold(8'(19 + rdb(r)), 300);
         check("rel_below", {9'h000, carrier_sense_o}, 10'h000);
         hold(8'(20 + rdb(r)), 300);
         check("rel_at", {9'h000, carrier_sense_o}, 10'h001);
      end
      check("irq_masked", {9'h000, irq_o}, 10'h000);
      rd(ACS_IRQ_STAT_OFS, 8'h03, "stat_both");
      wr(ACS_IRQ_MASK_OFS, 8'h03);
      @(posedge clk_i);
      #1 check("irq_on", {9'h000, irq_o}, 10'h001);
      wr(ACS_IRQ_STAT_OFS, 8'h01);
      rd(ACS_IRQ_STAT_OFS, 8'h02, "stat_clr");
      wr(ACS_IRQ_MASK_OFS, 8'h01);
      @(posedge clk_i);
      #1 check("irq_off", {9'h000, irq_o}, 10'h000);
      wr(ACS_IRQ_STAT_OFS, 8'h02);
      rd(ACS_IRQ_STAT_OFS, 8'h00, "stat_empty");
      wr(ACS_PRIO_THR_OFS, 8'h48);
      for (int k = 0; k < 8; k++) begin
         wr(ACS_GAIN_LIMITS_OFS, {2'(k), 3'(k), 3'h0});
         hold(8'h14, 150);
         check("dig_ceil", {7'h00, digital_gain_o}, 10'(7 - (k % 4)));
         check("front_ceil", 10'(first_stage_red_o) + 10'(second_stage_red_o), 10'(k));
      end
      close_out();
   end
endmodule

// ---- testbench/acs_chain_model.sv ----
module acs_chain_model import acs_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] level_i,
   input wire logic [2:0] first_i,
   input wire logic [2:0] second_i,
   input wire logic [2:0] dig_i,
   output logic [7:0] amp_db_o,
   output logic amp_valid_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_r;
   logic [9:0] red;
   logic [7:0] amp;
   // each stage step and each digital step lowers the amplitude by 3 dB
   always_comb begin
      red = 10'(3 * (int'(first_i) + int'(second_i) + 7 - int'(dig_i)));
      amp = (red > {2'b00, level_i}) ? 8'h00 : 8'({2'b00, level_i} - red);
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   // samples back to back and with gaps
   assign amp_valid_o = rst_b_i && (cnt_r == 3'h0 || cnt_r == 3'h1 || cnt_r == 3'h5);
   // between samples the amplitude line carries no stale value
   assign amp_db_o = amp_valid_o ? amp : ~amp;
endmodule
